// *** common/dpio_cfg.svh ***
`ifndef DPIO_CFG_SVH
`define DPIO_CFG_SVH

// ----------------------------------------------------------------------
// Register byte offsets (haddr[7:0]).
// ----------------------------------------------------------------------
`define DPIO_OFS_LV_DATA   8'h00
`define DPIO_OFS_HV_DATA   8'h04
`define DPIO_OFS_LV_DIR    8'h08
`define DPIO_OFS_HV_DIR    8'h0C
`define DPIO_OFS_CFG2      8'h10
`define DPIO_OFS_STATUS    8'h14
`define DPIO_OFS_IRQ_STAT  8'h18
`define DPIO_OFS_IRQ_EN    8'h1C
`define DPIO_OFS_IRQ_CLR   8'h20

// ----------------------------------------------------------------------
// Field positions.
// ----------------------------------------------------------------------
`define DPIO_CFG_LEVEL_BIT 0
`define DPIO_CFG_W4_BIT    1
`define DPIO_CFG_SR_BIT    2
`define DPIO_STAT_PCWF_BIT 7
`define DPIO_STAT_ARM_BIT  0
`define DPIO_IRQ_W4_BIT    0
`define DPIO_IRQ_SR_BIT    1

// ----------------------------------------------------------------------
// Reset values.
// ----------------------------------------------------------------------
`define DPIO_RST_DRV_LV    4'h0
`define DPIO_RST_DRV_HV    8'h00
`define DPIO_RST_CFG       3'h0
`define DPIO_RST_PCWF      1'b1

// ----------------------------------------------------------------------
// Timing: slow-rise pin must stay high this long before it counts.
// ----------------------------------------------------------------------
`define DPIO_CLK_PERIOD_NS 50
`define DPIO_SR_FILT_NS    1000
`define DPIO_SR_FILT_CYC   ((`DPIO_SR_FILT_NS + `DPIO_CLK_PERIOD_NS - 1) / `DPIO_CLK_PERIOD_NS)
`define DPIO_SR_CNT_W      5

`endif

// *** common/dpio_pkg.sv ***
package dpio_pkg;

  // ----------------------------------------------------------------------
  // Sleep and wake sequencing, one-hot.
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_RUN   = 3'b001,
    ST_ARMED = 3'b010,
    ST_WAKE  = 3'b100
  } dpio_state_t;

  // Whole state of the top module.
  typedef struct packed {
    dpio_state_t st;
    logic        rdy;
    logic        wr_pend;
    logic [7:0]  wr_addr;
    logic [31:0] rdata;
    logic [3:0]  lv_lat;
    logic [7:0]  hv_lat;
    logic [3:0]  lv_drv;
    logic [7:0]  hv_drv;
    logic [2:0]  cfg;
    logic        pcwf;
    logic [3:0]  ref_lvl;
    logic [4:0]  sr_cnt;
    logic        wake_rst;
    logic [1:0]  irq_st;
    logic [1:0]  irq_en;
    logic        irq;
  } dpio_top_st_t;

  // Whole state of the input synchroniser.
  typedef struct packed {
    logic [11:0] meta;
    logic [11:0] stab;
  } dpio_sync_st_t;

endpackage

// *** common/dpio_sync_if.sv ***
`timescale 1ns/10ps

// Raw pin levels in, two-stage synchronised levels out.
interface dpio_sync_if;
  logic [11:0] raw;
  logic [11:0] sync;

  modport syncer (input raw, output sync);
  modport user (output raw, input sync);
endinterface

// *** verilog/dpio_sync.sv ***
`timescale 1ns/10ps

module dpio_sync
  import dpio_pkg::*;
(
  input  wire logic   ref_clk_in,  // Core clock.
  input  wire logic   rst_n_in,    // Synchronous reset, active low.
  dpio_sync_if.syncer pins         // Raw and synchronised pin levels.
);

  dpio_sync_st_t q;
  dpio_sync_st_t d;

  // The first stage feeds only the second, so metastability never
  // reaches the decode logic.
  always_comb begin
    d      = q;
    d.meta = pins.raw;
    d.stab = q.meta;
  end

  // Register the state.
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign pins.sync = q.stab;

endmodule

// *** verilog/dpio_top.sv ***
// Our own choices: the AHB-Lite slave port and the register addresses.
`timescale 1ns/10ps
`include "dpio_cfg.svh"

// Functional notes
// - Port data reads return synchronised pin levels, never the output latches.
// - Reset sets every direction bit, making all pins high-impedance inputs.
// - Low-voltage port has four pins; upper bits read as zero.
// - Configuration level-select bit picks the regulated pad supply level.
// - High-voltage port has eight bidirectional pins.
// - Five high-voltage pins can wake: bits zero to three and seven.
// - Entering sleep captures high-port bits zero to three as reference.
// - During sleep a monitored pin differing from reference triggers reset.
// - A pin-change reset clears the pin-change wake flag.
// - Configuration bits enable four-pin wake and slow-rise wake separately.
// - Top high-voltage pin wakes on a filtered, slowly rising high.
// - Only pins set as inputs may cause a wake reset.
// - Direction one tristates the driver; zero drives the latch value.
// - Output latches hold until software writes the port again.
// - A pin-change wake is a full reset, not a resume.
module dpio_top
  import dpio_pkg::*;
(
  input  wire logic        ref_clk_in,            // Core clock, 20 MHz.
  input  wire logic        rst_n_in,              // Synchronous reset, active low.
  input  wire logic        hsel_in,               // AHB slave select.
  input  wire logic [31:0] haddr_in,              // AHB address.
  input  wire logic [1:0]  htrans_in,             // AHB transfer type.
  input  wire logic        hwrite_in,             // AHB write flag.
  input  wire logic [2:0]  hsize_in,              // AHB size, words only.
  input  wire logic [31:0] hwdata_in,             // AHB write data.
  input  wire logic        hready_in,             // AHB bus ready.
  output logic      [31:0] hrdata_out,            // AHB read data.
  output logic             hreadyout_out,         // AHB slave ready.
  output logic             hresp_out,             // AHB response, OKAY.
  input  wire logic        sleep_in,              // Core is in sleep.
  input  wire logic [3:0]  low_voltage_pins_in,   // Low port pin levels.
  output logic      [3:0]  low_voltage_pins_out,  // Low port drive values.
  output logic      [3:0]  low_voltage_pins_oe_out, // Low port drive enables.
  input  wire logic [7:0]  high_voltage_port_in,  // High port pin levels.
  output logic      [7:0]  high_voltage_port_out, // High port drive values.
  output logic      [7:0]  high_voltage_port_oe_out, // High port drive enables.
  output logic             pad_level_select_out,  // Regulated pad supply level.
  output logic             wake_reset_out,        // One-cycle device reset request.
  output logic             irq_out                // Level interrupt.
);

  // ----------------------------------------------------------------------
  // Pin synchronisers.
  // ----------------------------------------------------------------------

  dpio_sync_if sync_bus ();

  // Pins are asynchronous to the core clock.
  assign sync_bus.raw = {high_voltage_port_in, low_voltage_pins_in};

  dpio_sync u_sync (
    .ref_clk_in (ref_clk_in),
    .rst_n_in   (rst_n_in),
    .pins       (sync_bus.syncer)
  );

  logic [3:0] lv_sync;
  logic [7:0] hv_sync;

  assign lv_sync = sync_bus.sync[3:0];
  assign hv_sync = sync_bus.sync[11:4];

  // ----------------------------------------------------------------------
  // State registers.
  // ----------------------------------------------------------------------

  dpio_top_st_t q;
  dpio_top_st_t d;

  localparam logic [4:0] SR_CYC = 5'(`DPIO_SR_FILT_CYC);

  // Next-state logic: bus, ports, sleep and wake, interrupts.
  always_comb begin
    logic        addr_ph;
    logic [31:0] rd_val;
    logic        chg_wake;
    logic        sr_wake;
    logic [1:0]  irq_clr;
    logic [1:0]  irq_ev;
    addr_ph  = 1'b0;
    rd_val   = 32'h0000_0000;
    chg_wake = 1'b0;
    sr_wake  = 1'b0;
    irq_clr  = 2'h0;
    irq_ev   = 2'h0;

    d          = q;
    d.rdy      = 1'b1;
    d.wake_rst = 1'b0;

    // Address phase is taken only when the bus is ready.
    addr_ph   = hsel_in & hready_in & htrans_in[1];
    d.wr_pend = addr_ph & hwrite_in;
    if (addr_ph) begin
      d.wr_addr = haddr_in[7:0];
    end

    // Read mux; unmapped and write-only offsets read as zero.
    case (haddr_in[7:0])
      `DPIO_OFS_LV_DATA: begin
        rd_val = {28'h0000000, lv_sync};
      end
      `DPIO_OFS_HV_DATA: begin
        rd_val = {24'h000000, hv_sync};
      end
      `DPIO_OFS_LV_DIR: begin
        rd_val = {28'h0000000, ~q.lv_drv};
      end
      `DPIO_OFS_HV_DIR: begin
        rd_val = {24'h000000, ~q.hv_drv};
      end
      `DPIO_OFS_CFG2: begin
        rd_val = {29'h00000000, q.cfg};
      end
      `DPIO_OFS_STATUS: begin
        rd_val[`DPIO_STAT_PCWF_BIT] = q.pcwf;
        rd_val[`DPIO_STAT_ARM_BIT]  = q.st[1];
      end
      `DPIO_OFS_IRQ_STAT: begin
        rd_val = {30'h00000000, q.irq_st};
      end
      `DPIO_OFS_IRQ_EN: begin
        rd_val = {30'h00000000, q.irq_en};
      end
      default: begin
        rd_val = 32'h0000_0000;
      end
    endcase
    if (addr_ph & ~hwrite_in) begin
      d.rdata = rd_val;
    end

    // Data phase of a write lands one cycle after its address phase.
    if (q.wr_pend) begin
      case (q.wr_addr)
        `DPIO_OFS_LV_DATA: begin
          d.lv_lat = hwdata_in[3:0];
        end
        `DPIO_OFS_HV_DATA: begin
          d.hv_lat = hwdata_in[7:0];
        end
        `DPIO_OFS_LV_DIR: begin
          d.lv_drv = ~hwdata_in[3:0];
        end
        `DPIO_OFS_HV_DIR: begin
          d.hv_drv = ~hwdata_in[7:0];
        end
        `DPIO_OFS_CFG2: begin
          d.cfg = hwdata_in[2:0];
        end
        `DPIO_OFS_IRQ_EN: begin
          d.irq_en = hwdata_in[1:0];
        end
        `DPIO_OFS_IRQ_CLR: begin
          irq_clr = hwdata_in[1:0];
        end
        default: begin
          d.cfg = q.cfg;
        end
      endcase
    end

    chg_wake = q.cfg[`DPIO_CFG_W4_BIT] &
               (|((hv_sync[3:0] ^ q.ref_lvl) & ~q.hv_drv[3:0]));

    sr_wake = q.cfg[`DPIO_CFG_SR_BIT] & ~q.hv_drv[7] & (q.sr_cnt == SR_CYC);

    // Sleep sequencing.
    case (q.st)
      ST_RUN: begin
        d.sr_cnt = 5'h00;
        if (sleep_in) begin
          d.ref_lvl = hv_sync[3:0];
          d.st      = ST_ARMED;
        end
      end
      ST_ARMED: begin
        // The filter restarts on any low, so a slow ramp with bounce
        // must settle high for the whole window before it counts.
        if (!hv_sync[7]) begin
          d.sr_cnt = 5'h00;
        end else if (q.sr_cnt != SR_CYC) begin
          d.sr_cnt = q.sr_cnt + 5'h01;
        end
        if (!sleep_in) begin
          d.st = ST_RUN;
        end else if (chg_wake | sr_wake) begin
          d.st       = ST_WAKE;
          d.wake_rst = 1'b1;
          d.pcwf     = 1'b0;
          d.lv_drv   = `DPIO_RST_DRV_LV;
          d.hv_drv   = `DPIO_RST_DRV_HV;
          irq_ev[`DPIO_IRQ_W4_BIT] = chg_wake;
          irq_ev[`DPIO_IRQ_SR_BIT] = sr_wake;
        end
      end
      ST_WAKE: begin
        d.st     = ST_RUN;
        d.sr_cnt = 5'h00;
      end
      default: begin
        d.st = ST_RUN;
      end
    endcase

    // A new event wins over a clear in the same cycle.
    d.irq_st = (q.irq_st & ~irq_clr) | irq_ev;
    d.irq    = |(d.irq_st & d.irq_en);
  end

  // ----------------------------------------------------------------------
  // Register the state.
  // ----------------------------------------------------------------------

  // The latches survive the wake path but not the external reset.
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      q.st       <= ST_RUN;
      q.rdy      <= 1'b1;
      q.wr_pend  <= 1'b0;
      q.wr_addr  <= 8'h00;
      q.rdata    <= 32'h0000_0000;
      q.lv_lat   <= 4'h0;
      q.hv_lat   <= 8'h00;
      q.lv_drv   <= `DPIO_RST_DRV_LV;
      q.hv_drv   <= `DPIO_RST_DRV_HV;
      q.cfg      <= `DPIO_RST_CFG;
      q.pcwf     <= `DPIO_RST_PCWF;
      q.ref_lvl  <= 4'h0;
      q.sr_cnt   <= 5'h00;
      q.wake_rst <= 1'b0;
      q.irq_st   <= 2'h0;
      q.irq_en   <= 2'h0;
      q.irq      <= 1'b0;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs, all from flip-flops except the tied-off hresp_out.
  // ----------------------------------------------------------------------

  assign hrdata_out               = q.rdata;
  assign hreadyout_out            = q.rdy;
  // Every transfer completes without error.
  assign hresp_out                = 1'b0;

  assign low_voltage_pins_out     = q.lv_lat;
  assign low_voltage_pins_oe_out  = q.lv_drv;

  assign high_voltage_port_out    = q.hv_lat;
  assign high_voltage_port_oe_out = q.hv_drv;

  assign pad_level_select_out     = q.cfg[`DPIO_CFG_LEVEL_BIT];

  assign wake_reset_out           = q.wake_rst;
  assign irq_out                  = q.irq;

endmodule

// *** verification/dpio_top_props.sv ***
`timescale 1ns/10ps
`include "dpio_cfg.svh"

module dpio_top_props (
  input wire logic        ref_clk_in,               // Core clock.
  input wire logic        rst_n_in,                 // Reset, active low.
  input wire logic        hsel_in,                  // Select.
  input wire logic [31:0] haddr_in,                 // Address.
  input wire logic [1:0]  htrans_in,                // Transfer type.
  input wire logic        hwrite_in,                // Write flag.
  input wire logic [31:0] hwdata_in,                // Write data.
  input wire logic        hready_in,                // Bus ready.
  input wire logic        hreadyout_out,            // Slave ready.
  input wire logic        hresp_out,                // Response.
  input wire logic        sleep_in,                 // Sleep level.
  input wire logic [3:0]  low_voltage_pins_oe_out,  // Low enables.
  input wire logic [7:0]  high_voltage_port_out,    // High values.
  input wire logic [7:0]  high_voltage_port_oe_out, // High enables.
  input wire logic        pad_level_select_out,     // Pad level.
  input wire logic        wake_reset_out            // Wake pulse.
);
  logic tk;
  logic dp_q;

  // A taken write address phase; the data lands one edge later.
  assign tk = hsel_in && hready_in && htrans_in[1] && hwrite_in;

  // Marks the data phase of a high port data write.
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      dp_q <= 1'b0;
    end else begin
      dp_q <= tk && haddr_in[7:0] == `DPIO_OFS_HV_DATA;
    end
  end

  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!rst_n_in);

  sequence s_wr(logic [7:0] a);
    tk && haddr_in[7:0] == a;
  endsequence

  AST_BUS: assert property (hreadyout_out && !hresp_out)
    else $error("bus not ready or not okay");
  AST_RST_DIR: assert property ($rose(rst_n_in) |->
    low_voltage_pins_oe_out == 4'h0 && high_voltage_port_oe_out == 8'h00)
    else $error("pins driven after reset");
  AST_WAKE_PULSE: assert property (wake_reset_out |=> !wake_reset_out)
    else $error("wake pulse longer than one cycle");
  AST_WAKE_IN: assert property (wake_reset_out |-> high_voltage_port_oe_out == 8'h00)
    else $error("pins still driven at wake");
  AST_WAKE_SLEEP: assert property (wake_reset_out |-> $past(sleep_in))
    else $error("wake outside sleep");
  AST_PAD: assert property (s_wr(`DPIO_OFS_CFG2) ##1 1'b1 |=>
    pad_level_select_out == $past(hwdata_in[0]))
    else $error("pad level not updated");
  AST_HV_DIR: assert property (s_wr(`DPIO_OFS_HV_DIR) ##1 1'b1 |=>
    high_voltage_port_oe_out == ~$past(hwdata_in[7:0]))
    else $error("high enables wrong");
  AST_LV_DIR: assert property (s_wr(`DPIO_OFS_LV_DIR) ##1 1'b1 |=>
    low_voltage_pins_oe_out == ~$past(hwdata_in[3:0]))
    else $error("low enables wrong");
  AST_HOLD: assert property ($changed(high_voltage_port_out) |-> $past(dp_q))
    else $error("latch moved without write");
endmodule

bind dpio_top dpio_top_props u_dpio_top_props (.ref_clk_in, .rst_n_in, .hsel_in, .haddr_in,
  .htrans_in, .hwrite_in, .hwdata_in, .hready_in, .hreadyout_out, .hresp_out, .sleep_in,
  .low_voltage_pins_oe_out, .high_voltage_port_out, .high_voltage_port_oe_out,
  .pad_level_select_out, .wake_reset_out);

// *** verification/dpio_pins_model.sv ***
`timescale 1ns/10ps

module dpio_pins_model (
  input  wire logic [3:0] lv_out_in, // Low drive values.
  input  wire logic [3:0] lv_oe_in,  // Low drive enables.
  input  wire logic [3:0] lv_ext_in, // Outside low levels.
  input  wire logic [7:0] hv_out_in, // High drive values.
  input  wire logic [7:0] hv_oe_in,  // High drive enables.
  input  wire logic [7:0] hv_ext_in, // Outside high levels.
  output logic      [3:0] lv_pin_out, // Low wire levels.
  output logic      [7:0] hv_pin_out  // High wire levels.
);
  // defined levels
  // Outside circuitry always holds a level, so an undriven pin never floats.
  assign lv_pin_out = (lv_oe_in & lv_out_in) | (~lv_oe_in & lv_ext_in);
  assign hv_pin_out = (hv_oe_in & hv_out_in) | (~hv_oe_in & hv_ext_in);
endmodule

// *** verification/test_dpio.sv ***
`timescale 1ns/10ps
`include "dpio_cfg.svh"

module test_dpio;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic        sleep = 1'b0;
  logic [3:0]  lv_ext = 4'h0;
  logic [7:0]  hv_ext = 8'h3C;
  logic [31:0] hrdata;
  logic        hrdy;
  logic [3:0]  lv_pin, lv_out, lv_oe;
  logic [7:0]  hv_pin, hv_out, hv_oe;
  logic        pad, wake, irq;
  int          fails = 0;
  int          comparisons = 0;
  int          cycles = 0;
  int          wakes = 0;

  always #25 clk = ~clk;

  dpio_top u_dpio_top (.ref_clk_in(clk), .rst_n_in(rst_n), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
    .hready_in(hrdy), .hrdata_out(hrdata), .hreadyout_out(hrdy), .hresp_out(),
    .sleep_in(sleep), .low_voltage_pins_in(lv_pin), .low_voltage_pins_out(lv_out),
    .low_voltage_pins_oe_out(lv_oe), .high_voltage_port_in(hv_pin),
    .high_voltage_port_out(hv_out), .high_voltage_port_oe_out(hv_oe),
    .pad_level_select_out(pad), .wake_reset_out(wake), .irq_out(irq));

  dpio_pins_model u_dpio_pins_model (.lv_out_in(lv_out), .lv_oe_in(lv_oe), .lv_ext_in(lv_ext),
    .hv_out_in(hv_out), .hv_oe_in(hv_oe), .hv_ext_in(hv_ext), .lv_pin_out(lv_pin),
    .hv_pin_out(hv_pin));

  // Counts wake pulses and cuts a hang short.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (wake === 1'b1) wakes <= wakes + 1;
    if (cycles == 3000) begin
      fails = fails + 1;
      complete_run;
    end
  end

  // ----------------------------------------------------------------------
  // Bus and compare tasks.
  // ----------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One single transfer; read data is taken at the edge ending the data phase.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge clk);
    while (hrdy !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hrdy !== 1'b1) @(posedge clk);
    r = hrdata;
    @(negedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    xfer(1'b1, a, d, r);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    xfer(1'b0, a, 32'h0, r);
    chk(r, e);
  endtask

  task automatic wait_wake(input int n);
    for (int i = 0; i < 40 && wakes < n; i++) @(posedge clk);
    @(negedge clk);
  endtask

  task complete_run;
    if (fails == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Main sequence.
  // ----------------------------------------------------------------------
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    chk(hv_oe, 8'h00);
    rchk(`DPIO_OFS_HV_DIR, 32'hFF);
    rchk(`DPIO_OFS_LV_DIR, 32'h0F);
    rchk(`DPIO_OFS_STATUS, 32'h80);
    wr(`DPIO_OFS_HV_DATA, 32'hA5);
    chk(hv_out, 8'hA5);
    wr(`DPIO_OFS_HV_DIR, 32'h0F);
    chk(hv_oe, 8'hF0);
    repeat (4) @(posedge clk);
    rchk(`DPIO_OFS_HV_DATA, 32'hAC);
    wr(`DPIO_OFS_LV_DATA, 32'hFF);
    repeat (4) @(posedge clk);
    rchk(`DPIO_OFS_LV_DATA, 32'h00);
    wr(`DPIO_OFS_LV_DIR, 32'h00);
    repeat (4) @(posedge clk);
    rchk(`DPIO_OFS_LV_DATA, 32'h0F);
    wr(`DPIO_OFS_CFG2, 32'h1);
    chk(pad, 1'b1);
    rchk(8'h40, 32'h0);
    // Four-pin wake disabled: a change must not wake.
    @(posedge clk) sleep <= 1'b1;
    repeat (4) @(posedge clk);
    hv_ext <= 8'h3D;
    repeat (10) @(posedge clk);
    chk(wakes, 0);
    // Still armed and the wake flag still set, since nothing fired.
    rchk(`DPIO_OFS_STATUS, 32'h81);
    @(posedge clk) sleep <= 1'b0;
    wr(`DPIO_OFS_CFG2, 32'h3);
    wr(`DPIO_OFS_IRQ_EN, 32'h1);
    @(posedge clk) sleep <= 1'b1;
    repeat (4) @(posedge clk);
    hv_ext <= 8'h39;
    wait_wake(1);
    chk(wakes, 1);
    chk(hv_oe, 8'h00);
    @(posedge clk) sleep <= 1'b0;
    rchk(`DPIO_OFS_STATUS, 32'h00);
    rchk(`DPIO_OFS_IRQ_STAT, 32'h1);
    chk(irq, 1'b1);
    wr(`DPIO_OFS_IRQ_CLR, 32'h1);
    chk(irq, 1'b0);
    // Slow rise: held low, then high; the filter must let it through late.
    wr(`DPIO_OFS_CFG2, 32'h5);
    wr(`DPIO_OFS_IRQ_EN, 32'h3);
    @(posedge clk) sleep <= 1'b1;
    repeat (4) @(posedge clk);
    hv_ext <= 8'hB9;
    repeat (15) @(posedge clk);
    chk(wakes, 1);
    wait_wake(2);
    chk(wakes, 2);
    @(posedge clk) sleep <= 1'b0;
    rchk(`DPIO_OFS_IRQ_STAT, 32'h2);
    chk(irq, 1'b1);
    wr(`DPIO_OFS_IRQ_EN, 32'h1);
    chk(irq, 1'b0);
    wr(`DPIO_OFS_IRQ_CLR, 32'h2);
    rchk(`DPIO_OFS_IRQ_STAT, 32'h0);
    complete_run;
  end
endmodule
